//--- hdl/pfc_pkg.sv
package pfc_pkg;
    localparam logic [11:0] PFC_REG_OFFSET = 12'h1a4;
    localparam int PFC_BIT_BP = 6;
    localparam int PFC_BIT_DUP = 5;
    localparam int PFC_BIT_CUR_RX = 4;
    localparam int PFC_BIT_CUR_TX = 3;
    localparam int PFC_BIT_RX_EN = 2;
    localparam int PFC_BIT_TX_EN = 1;
    localparam int PFC_BIT_MANUAL = 0;
    localparam int PFC_FIELD_W = 7;
    localparam logic [31:0] PFC_RESERVED_VALUE = 32'h0000_0000;
    localparam logic PFC_RESET_BP = 1'b0;
    localparam logic PFC_RESET_PAUSE = 1'b0;
    localparam logic PFC_RESET_MANUAL = 1'b0;
    localparam logic [2:0] PFC_SYNC_RESET = 3'h0;
endpackage : pfc_pkg

//--- hdl/pfc_sync.sv
module pfc_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    import pfc_pkg::*;
    logic [2:0] stage;

    // stage[0] feeds only stage[1]; change taken once stages 1 and 2 agree
    always_ff @(posedge clk) begin
        if (rst) begin
            stage <= PFC_SYNC_RESET;
        end else begin
            stage <= {stage[1:0], din};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dout <= 1'b0;
        end else if (stage[2] == stage[1]) begin
            dout <= stage[2];
        end
    end
endmodule : pfc_sync

//--- hdl/pfc_port2_flow_control.sv
// Functional notes
// - bit 6 backpressure enable drives half-duplex backpressure output.
// - bit 5 reads current duplex, 0 full, 1 half.
// - bit 4 reads one while pause receive is active.
// - bit 3 reads one while pause transmit is active.
// - bit 2 enables pause detection when manual or negotiation disabled.
// - bit 1 enables pause generation when manual or negotiation disabled.
// - manual zero with negotiation on uses negotiated result; enables ignored.
// - manual one lets enables alone set flow control in full duplex.
// - reads return flow control actually in effect.
// - writes never touch the phy negotiation advertisement.
// - reset clears fields; straps load on the first cycle after release.
// - loader strap rewrite updates the register fields.
module pfc_port2_flow_control (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [11:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] WDATA,
    output logic [31:0] RDATA,
    input wire logic BACKPRESSURE_STRAP,
    input wire logic FULL_DUPLEX_PAUSE_STRAP,
    input wire logic MANUAL_SELECT_STRAP,
    input wire logic STRAP_RELOAD,
    input wire logic HALF_DUPLEX,
    input wire logic AN_ENABLE,
    input wire logic AN_PAUSE_RX,
    input wire logic AN_PAUSE_TX,
    output logic BACKPRESSURE_ENABLE,
    output logic CURRENT_PAUSE_RX,
    output logic CURRENT_PAUSE_TX
);
    import pfc_pkg::*;

    logic backpressure_enable;
    logic pause_rx_enable;
    logic pause_tx_enable;
    logic manual_select;
    logic reset_seen;
    logic current_duplex;
    logic an_enable_s;
    logic an_rx_s;
    logic an_tx_s;
    logic next_rx;
    logic next_tx;
    logic hit;
    logic load;
    logic write_hit;
    logic read_hit;
    logic negotiated;
    logic [31:0] next_rdata;

    // link status arrives from the phy side, so it is resynchronised
    pfc_sync u_sync_dup (
        .clk(CLK),
        .rst(SYS_RST),
        .din(HALF_DUPLEX),
        .dout(current_duplex)
    );

    pfc_sync u_sync_an (
        .clk(CLK),
        .rst(SYS_RST),
        .din(AN_ENABLE),
        .dout(an_enable_s)
    );

    // rx and tx results may settle a cycle apart; a short mixed state is harmless
    pfc_sync u_sync_anrx (
        .clk(CLK),
        .rst(SYS_RST),
        .din(AN_PAUSE_RX),
        .dout(an_rx_s)
    );

    pfc_sync u_sync_antx (
        .clk(CLK),
        .rst(SYS_RST),
        .din(AN_PAUSE_TX),
        .dout(an_tx_s)
    );

    assign hit = (ADDR == PFC_REG_OFFSET);
    assign write_hit = WR && hit;
    assign read_hit = RD && hit;
    // straps are caught on the first cycle after reset release, never under reset
    assign load = !reset_seen || STRAP_RELOAD;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            reset_seen <= 1'h0;
        end else begin
            reset_seen <= 1'h1;
        end
    end

    // loader rewrite wins over a software write in the same cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            backpressure_enable <= PFC_RESET_BP;
        end else if (load) begin
            backpressure_enable <= BACKPRESSURE_STRAP;
        end else if (write_hit) begin
            backpressure_enable <= WDATA[PFC_BIT_BP];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pause_rx_enable <= PFC_RESET_PAUSE;
        end else if (load) begin
            pause_rx_enable <= FULL_DUPLEX_PAUSE_STRAP;
        end else if (write_hit) begin
            pause_rx_enable <= WDATA[PFC_BIT_RX_EN];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pause_tx_enable <= PFC_RESET_PAUSE;
        end else if (load) begin
            pause_tx_enable <= FULL_DUPLEX_PAUSE_STRAP;
        end else if (write_hit) begin
            pause_tx_enable <= WDATA[PFC_BIT_TX_EN];
        end
    end

    // no path leads to the phy advertisement; it stays as negotiated
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            manual_select <= PFC_RESET_MANUAL;
        end else if (load) begin
            manual_select <= MANUAL_SELECT_STRAP;
        end else if (write_hit) begin
            manual_select <= WDATA[PFC_BIT_MANUAL];
        end
    end

    // negotiated result only rules when manual is off and negotiation is on
    assign negotiated = !manual_select && an_enable_s;

    // pause only meaningful in full duplex, so half duplex forces both off
    always_comb begin
        if (current_duplex) begin
            next_rx = 1'h0;
            next_tx = 1'h0;
        end else if (negotiated) begin
            next_rx = an_rx_s;
            next_tx = an_tx_s;
        end else begin
            next_rx = pause_rx_enable;
            next_tx = pause_tx_enable;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            CURRENT_PAUSE_RX <= 1'h0;
        end else begin
            CURRENT_PAUSE_RX <= next_rx;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            CURRENT_PAUSE_TX <= 1'h0;
        end else begin
            CURRENT_PAUSE_TX <= next_tx;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            BACKPRESSURE_ENABLE <= 1'h0;
        end else begin
            BACKPRESSURE_ENABLE <= backpressure_enable;
        end
    end

    // pause status bits 4 and 3 come from the output flops so a read matches the pins; bit 5 comes from the synchroniser
    always_comb begin
        next_rdata = PFC_RESERVED_VALUE;
        next_rdata[PFC_BIT_BP] = backpressure_enable;
        next_rdata[PFC_BIT_DUP] = current_duplex;
        next_rdata[PFC_BIT_CUR_RX] = CURRENT_PAUSE_RX;
        next_rdata[PFC_BIT_CUR_TX] = CURRENT_PAUSE_TX;
        next_rdata[PFC_BIT_RX_EN] = pause_rx_enable;
        next_rdata[PFC_BIT_TX_EN] = pause_tx_enable;
        next_rdata[PFC_BIT_MANUAL] = manual_select;
    end

    // registered read data; one cycle latency, zero when not read
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RDATA <= PFC_RESERVED_VALUE;
        end else if (read_hit) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= PFC_RESERVED_VALUE;
        end
    end

endmodule : pfc_port2_flow_control

//--- verif/pfc_checker.sv
module pfc_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [11:0] ADDR,
    input wire logic RD,
    input wire logic STRAP_RELOAD,
    input wire logic HALF_DUPLEX,
    input wire logic BACKPRESSURE_STRAP,
    input wire logic [31:0] RDATA,
    input wire logic BACKPRESSURE_ENABLE,
    input wire logic CURRENT_PAUSE_RX,
    input wire logic CURRENT_PAUSE_TX
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire hit = RD && ADDR == 12'h1a4;
    AST_IDLE: assert property (!hit |=> RDATA == 32'h0) else $error("rdata not idle");
    AST_BP: assert property (hit |=> RDATA[6] == BACKPRESSURE_ENABLE) else $error("bp");
    AST_RX: assert property (hit |=> RDATA[4] == $past(CURRENT_PAUSE_RX)) else $error("rx");
    AST_TX: assert property (hit |=> RDATA[3] == $past(CURRENT_PAUSE_TX)) else $error("tx");
    AST_HALF: assert property (HALF_DUPLEX [*8] |-> !CURRENT_PAUSE_RX && !CURRENT_PAUSE_TX)
        else $error("pause in half duplex");
    AST_DUP: assert property ($stable(HALF_DUPLEX) [*8] ##0 hit
        |=> RDATA[5] == $past(HALF_DUPLEX)) else $error("duplex");
    AST_LOAD: assert property (STRAP_RELOAD |-> ##2
        BACKPRESSURE_ENABLE == $past(BACKPRESSURE_STRAP, 2)) else $error("reload");
    AST_RST: assert property ($fell(SYS_RST) |-> ##3
        BACKPRESSURE_ENABLE == BACKPRESSURE_STRAP) else $error("strap load");
endmodule : pfc_checker

//--- verif/tb.sv
module tb;
    timeunit 1ns / 1ns;
    logic CLK = 1'b0, SYS_RST = 1'b1, WR = 1'b0, RD = 1'b0, STRAP_RELOAD = 1'b0;
    logic HALF_DUPLEX = 1'b0, AN_ENABLE = 1'b0, AN_PAUSE_RX = 1'b0, AN_PAUSE_TX = 1'b0;
    logic BACKPRESSURE_STRAP = 1'b1, FULL_DUPLEX_PAUSE_STRAP = 1'b1, MANUAL_SELECT_STRAP = 1'b1;
    logic BACKPRESSURE_ENABLE, CURRENT_PAUSE_RX, CURRENT_PAUSE_TX;
    logic [11:0] ADDR = 12'h1a4;
    logic [31:0] WDATA = 32'h0, RDATA;
    int failures = 0, compares = 0;
    pfc_port2_flow_control i_dut (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .ADDR(ADDR),
        .WR(WR),
        .RD(RD),
        .WDATA(WDATA),
        .RDATA(RDATA),
        .BACKPRESSURE_STRAP(BACKPRESSURE_STRAP),
        .FULL_DUPLEX_PAUSE_STRAP(FULL_DUPLEX_PAUSE_STRAP),
        .MANUAL_SELECT_STRAP(MANUAL_SELECT_STRAP),
        .STRAP_RELOAD(STRAP_RELOAD),
        .HALF_DUPLEX(HALF_DUPLEX),
        .AN_ENABLE(AN_ENABLE),
        .AN_PAUSE_RX(AN_PAUSE_RX),
        .AN_PAUSE_TX(AN_PAUSE_TX),
        .BACKPRESSURE_ENABLE(BACKPRESSURE_ENABLE),
        .CURRENT_PAUSE_RX(CURRENT_PAUSE_RX),
        .CURRENT_PAUSE_TX(CURRENT_PAUSE_TX)
    );
    initial forever #20 CLK = ~CLK;
    task automatic chk(input logic [31:0] got, exp);
        compares++;
        failures += int'(got !== exp);
        if (got !== exp) $display("CHECK FAILED %0t got %h", $time, got);
    endtask : chk
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        repeat (8) @(negedge CLK); // lets synchronised status settle first
        {ADDR, WDATA, WR, RD} = {a, d, w, !w};
        @(negedge CLK);
        {WR, RD} = 2'h0;
        if (!w) chk(RDATA, d);
    endtask : acc
    task automatic t_flow;
        acc(1'b0, 12'h1a4, 32'h5f);
        acc(1'b1, 12'h1a4, 32'hffffff83);
        acc(1'b0, 12'h1a4, 32'hb);
        acc(1'b1, 12'h1a4, 32'h44);
        {AN_ENABLE, AN_PAUSE_TX} = 2'h3;
        acc(1'b0, 12'h1a4, 32'h4c);
        {HALF_DUPLEX, BACKPRESSURE_STRAP, MANUAL_SELECT_STRAP, STRAP_RELOAD} = 4'h9;
        @(negedge CLK);
        STRAP_RELOAD = 1'b0;
        acc(1'b0, 12'h1a4, 32'h26);
        $display("flow control test done");
    endtask : t_flow
    task automatic t_modes;
        HALF_DUPLEX = 1'b0;
        acc(1'b1, 12'h1a4, 32'h6);
        acc(1'b0, 12'h1a4, 32'he);
        chk({30'h0, CURRENT_PAUSE_RX, CURRENT_PAUSE_TX}, 32'h1);
        AN_ENABLE = 1'b0;
        acc(1'b0, 12'h1a4, 32'h1e);
        chk({30'h0, CURRENT_PAUSE_RX, CURRENT_PAUSE_TX}, 32'h3);
        {AN_ENABLE, AN_PAUSE_RX, AN_PAUSE_TX} = 3'h6;
        acc(1'b0, 12'h1a4, 32'h16);
        chk({30'h0, CURRENT_PAUSE_RX, CURRENT_PAUSE_TX}, 32'h2);
        acc(1'b1, 12'h1a4, 32'h47);
        acc(1'b0, 12'h1a4, 32'h5f);
        chk({31'h0, BACKPRESSURE_ENABLE}, 32'h1);
        acc(1'b1, 12'h1a0, 32'h0);
        acc(1'b0, 12'h1a8, 32'h0);
        acc(1'b0, 12'h1a4, 32'h5f);
        $display("mode test done");
    endtask : t_modes
    task automatic t_reset;
        {BACKPRESSURE_STRAP, FULL_DUPLEX_PAUSE_STRAP, MANUAL_SELECT_STRAP} = 3'h5;
        SYS_RST = 1'b1;
        repeat (8) @(negedge CLK);
        SYS_RST = 1'b0;
        @(negedge CLK);
        chk({31'h0, BACKPRESSURE_ENABLE}, 32'h0);
        acc(1'b0, 12'h1a4, 32'h41);
        chk({31'h0, BACKPRESSURE_ENABLE}, 32'h1);
        $display("reset test done");
    endtask : t_reset
    initial begin
        #320 SYS_RST = 1'b0;
        t_flow;
        t_modes;
        t_reset;
        final_report;
    end
    initial begin
        #100us failures++;
        final_report;
    end
    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
endmodule : tb
bind pfc_port2_flow_control pfc_checker i_chk (.*);
